// *** core/ctd_decode.v ***
// Purpose: Decode control-transfer opcodes and pace their execution clocks
// Assumes: Bytes arrive one per valid beat from the fetch queue, flags stable
// Notes:   Summary of operation list follows; byte_ready_o stays low for the full count
//          Timings include the queue refill only for transfers that branch
// Summary of operation
// - FF with mode middle 100 is indirect near jump, 7 plus address time
// - FF with mode middle 101 is indirect far jump, 16 plus address time
// - C2 plus 16-bit immediate, low first: near return, add to stack, 12
// - CA plus 16-bit immediate, low first: far return, add to stack, 17
// - Conditional jumps take one displacement byte; 8 taken, 4 not taken
// - Not-zero true when zero flag clear; zero true when set
// - Below true when carry flag set
// - Below-or-equal true when carry or zero flag set
// - Above true only when carry and zero flags both clear
// - Above-or-equal true when carry flag clear
// - Signed ge when sign equals overflow; signed lt when they differ
// - Signed gt when sign equals overflow and zero clear; le is complement
// - Parity odd when parity flag clear; parity even when set
// - Above/below compare unsigned; greater/less compare signed
// - Loop while zero / not zero: 11 clocks taken, 5 fall through
// - Jump if count zero branches on zero count; 9 taken, 5 not
// - Every transfer that branches adds 8 clocks for refilling the instruction queue
`timescale 1ns/100ps
`include "ctd_defines.vh"
module ctd_decode (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        byte_valid_i,
    input  wire [7:0]  byte_i,
    input  wire [7:0]  ea_clocks_i,
    input  wire        zero_flag_i,
    input  wire        carry_flag_i,
    input  wire        sign_flag_i,
    input  wire        overflow_flag_i,
    input  wire        parity_flag_i,
    input  wire [15:0] count_register_i,
    output wire        byte_ready_o,
    output reg         done_o,
    output reg         taken_o,
    output reg  [3:0]  kind_o,
    output reg  [15:0] operand_lo_o,
    output reg  [15:0] operand_hi_o,
    output reg         sp_add_o,
    output reg         count_write_o,
    output reg  [15:0] count_next_o,
    output reg  [7:0]  clocks_o
);
    // The decoder walks three phases: it takes an opcode, gathers the
    // operand bytes that opcode calls for, then counts down the clocks
    // the transfer would occupy on the core before reporting it.
    // Bytes are refused for the whole countdown, so the fetch queue
    // simply holds its head byte until the decoder is ready again.
    // Flags, count and address time are read combinationally; the core
    // must hold them steady from the opcode until done_o is reported.
    // A new instruction may start on the edge right after done_o.
    // Unknown opcodes are reported as kind F after one clock so a
    // stray byte cannot stall the stream.

    // Transfer kinds reported on kind_o
    localparam K_NONE = 4'h0;
    localparam K_JMP_NEAR = 4'h1;
    localparam K_JMP_SHORT = 4'h2;
    localparam K_JMP_FAR = 4'h3;
    localparam K_JMP_IND_NEAR = 4'h4;
    localparam K_JMP_IND_FAR = 4'h5;
    localparam K_RET_NEAR = 4'h6;
    localparam K_RET_FAR = 4'h7;
    localparam K_JCC = 4'h8;
    localparam K_LOOP = 4'h9;
    localparam K_JUMP_IF_COUNT_ZERO = 4'hA;
    localparam K_ILLEGAL = 4'hF;
    // Codes 4'hB to 4'hE stay free for call and interrupt forms later

    // Decoder states
    localparam S_OPC = 3'h0;
    localparam S_OPER = 3'h1;
    localparam S_EXEC = 3'h2;

    // Working state
    // opcode    - first byte of the running instruction
    // need, got - operand bytes expected and collected so far
    // oper      - operand bytes packed low byte first
    // remain    - clocks still to run; zero means load on next edge
    // cond, br  - flag test for 0x7x and the final branch decision
    // exec_clk  - total clocks charged, refill included when branching
    // cnt_dec   - count register less one, used by the loop forms
    reg [2:0]  state;
    reg [7:0]  opcode;
    reg [2:0]  need;
    reg [2:0]  got;
    reg [31:0] oper;
    reg [7:0]  remain;
    reg        cond;
    reg [7:0]  exec_clk;
    reg        br;
    reg [3:0]  kind;
    reg [2:0]  next_need;
    reg [15:0] cnt_dec;

    // Combinational ready lets the queue offer the next opcode the
    // very cycle after done_o, with no idle beat between transfers.
    // Take bytes only while decoding
    assign byte_ready_o = (state != S_EXEC);

    // Even codes test a flag or flag combination as set and the odd
    // code above each one is its exact complement. Above and below
    // read carry and zero, so they order unsigned operands; greater
    // and less read sign against overflow, so they order signed ones.

    // Flag condition for the 0x7x family
    always @* begin
        case (opcode[3:0])
            `CTD_CC_O:  cond = overflow_flag_i;
            `CTD_CC_NO: cond = ~overflow_flag_i;
            `CTD_CC_B:  cond = carry_flag_i;
            `CTD_CC_AE: cond = ~carry_flag_i;
            `CTD_CC_Z:  cond = zero_flag_i;
            `CTD_CC_NZ: cond = ~zero_flag_i;
            `CTD_CC_BE: cond = carry_flag_i | zero_flag_i;
            `CTD_CC_A:  cond = ~(carry_flag_i | zero_flag_i);
            `CTD_CC_S:  cond = sign_flag_i;
            `CTD_CC_NS: cond = ~sign_flag_i;
            `CTD_CC_PE: cond = parity_flag_i;
            `CTD_CC_PO: cond = ~parity_flag_i;
            `CTD_CC_L:  cond = sign_flag_i ^ overflow_flag_i;
            `CTD_CC_GE: cond = ~(sign_flag_i ^ overflow_flag_i);
            `CTD_CC_LE: cond = (sign_flag_i ^ overflow_flag_i) | zero_flag_i;
            default:    cond = ~((sign_flag_i ^ overflow_flag_i) | zero_flag_i);
        endcase
    end

    // Decoded straight from byte_i so need is ready on the same edge
    // that captures the opcode. Mode bytes of the FF group are counted
    // as one operand; displacement bytes of memory forms are not taken
    // here, their cost arrives as ea_clocks_i instead.

    // Operand bytes expected after each opcode
    always @* begin
        case (byte_i)
            `CTD_OP_JMP_NEAR:     next_need = 3'h2;
            `CTD_OP_JMP_SHORT:    next_need = 3'h1;
            `CTD_OP_JMP_FAR:      next_need = 3'h4;
            `CTD_OP_GROUP_FF:     next_need = 3'h1;
            `CTD_OP_RET_NEAR_IMM: next_need = 3'h2;
            `CTD_OP_RET_FAR_IMM:  next_need = 3'h2;
            `CTD_OP_LOOP_NZ,
            `CTD_OP_LOOP_Z,
            `CTD_OP_LOOP,
            `CTD_OP_JUMP_IF_COUNT_ZERO_OP:      next_need = 3'h1;
            default:              next_need = (byte_i[7:4] == `CTD_OP_JCC_HI) ? 3'h1 : 3'h0;
        endcase
    end

    // Runs on the captured opcode and operands, so the result is ready
    // on the edge after the last byte. The loop forms test the count as
    // it will be after the decrement, which is why a count of one
    // falls through. The count-zero jump tests the count before any
    // change, since it never decrements.
    // Limitation: exec_clk is eight bits, so an address time above
    // 231 clocks on the indirect far form wraps the total.

    // Classify the completed instruction and pick its clock count
    always @* begin
        cnt_dec = count_register_i - 16'h0001;
        br = 1'b0;
        kind = K_ILLEGAL;
        exec_clk = 8'h01;
        case (opcode)
            `CTD_OP_JMP_NEAR: begin
                kind = K_JMP_NEAR;
                br = 1'b1;
                exec_clk = `CTD_T_JMP_DIRECT;
            end
            `CTD_OP_JMP_SHORT: begin
                // One displacement byte, sign extension is left to the core
                kind = K_JMP_SHORT;
                br = 1'b1;
                exec_clk = `CTD_T_JMP_DIRECT;
            end
            `CTD_OP_JMP_FAR: begin
                // Offset lands in operand_lo_o and segment in operand_hi_o
                kind = K_JMP_FAR;
                br = 1'b1;
                exec_clk = `CTD_T_JMP_DIRECT;
            end
            // Other middle fields of the FF group are calls, pushes and
            // counts; they stay kind F here and run one clock
            `CTD_OP_GROUP_FF: begin
                if (oper[5:3] == `CTD_MID_JMP_IND_NEAR) begin
                    kind = K_JMP_IND_NEAR;
                    br = 1'b1;
                    exec_clk = `CTD_T_JMP_IND_NEAR + ea_clocks_i;
                end else if (oper[5:3] == `CTD_MID_JMP_IND_FAR) begin
                    kind = K_JMP_IND_FAR;
                    br = 1'b1;
                    exec_clk = `CTD_T_JMP_IND_FAR + ea_clocks_i;
                end
            end
            `CTD_OP_RET_NEAR: begin
                kind = K_RET_NEAR;
                br = 1'b1;
                exec_clk = `CTD_T_RET_NEAR;
            end
            `CTD_OP_RET_NEAR_IMM: begin
                // The immediate leaves on operand_lo_o with sp_add_o set
                kind = K_RET_NEAR;
                br = 1'b1;
                exec_clk = `CTD_T_RET_NEAR_IMM;
            end
            `CTD_OP_RET_FAR: begin
                kind = K_RET_FAR;
                br = 1'b1;
                exec_clk = `CTD_T_RET_FAR;
            end
            `CTD_OP_RET_FAR_IMM: begin
                kind = K_RET_FAR;
                br = 1'b1;
                exec_clk = `CTD_T_RET_FAR_IMM;
            end
            `CTD_OP_LOOP_NZ,
            `CTD_OP_LOOP_Z: begin
                // Bit 0 of the opcode gives the zero flag sense to match;
                // the branch also needs a count that stays nonzero
                kind = K_LOOP;
                br = (cnt_dec != 16'h0000) &
                     (zero_flag_i == opcode[0]);
                exec_clk = br ? `CTD_T_LOOP_TAKEN : `CTD_T_LOOP_NOT;
            end
            `CTD_OP_LOOP: begin
                // Plain loop ignores the flags and branches on count alone
                kind = K_LOOP;
                br = (cnt_dec != 16'h0000);
                exec_clk = br ? `CTD_T_LOOPB_TAKEN : `CTD_T_LOOPB_NOT;
            end
            `CTD_OP_JUMP_IF_COUNT_ZERO_OP: begin
                // Count is read but never written by this form
                kind = K_JUMP_IF_COUNT_ZERO;
                br = (count_register_i == 16'h0000);
                exec_clk = br ? `CTD_T_JUMP_IF_COUNT_ZERO_TAKEN : `CTD_T_JUMP_IF_COUNT_ZERO_NOT;
            end
            default: begin
                if (opcode[7:4] == `CTD_OP_JCC_HI) begin
                    kind = K_JCC;
                    br = cond;
                    exec_clk = cond ? `CTD_T_JCC_TAKEN : `CTD_T_JCC_NOT;
                end
            end
        endcase
        // Queue refill is charged only when control actually moves;
        // a jump that falls through keeps the prefetched bytes
        if (br)
            exec_clk = exec_clk + `CTD_T_QUEUE_REFILL;
    end

    // Every registered output is cleared by reset so the core never sees
    // a stale kind or clock count. done_o and count_write_o are pulses:
    // they drop on every edge unless the final countdown edge sets them.
    // The other outputs stand until the next done_o, except clocks_o, which changes when the countdown loads.

    // Byte collection, execution pacing and result reporting
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            // Back to waiting for an opcode with every output cleared
            state <= S_OPC;
            opcode <= 8'h00;
            need <= 3'h0;
            got <= 3'h0;
            oper <= 32'h0000_0000;
            remain <= 8'h00;
            done_o <= 1'b0;
            taken_o <= 1'b0;
            kind_o <= K_NONE;
            operand_lo_o <= 16'h0000;
            operand_hi_o <= 16'h0000;
            sp_add_o <= 1'b0;
            count_write_o <= 1'b0;
            count_next_o <= 16'h0000;
            clocks_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            count_write_o <= 1'b0;
            case (state)
                S_OPC: begin
                    // A zero-operand opcode goes straight to the countdown
                    if (byte_valid_i) begin
                        opcode <= byte_i;
                        need <= next_need;
                        got <= 3'h0;
                        oper <= 32'h0000_0000;
                        state <= (next_need == 3'h0) ? S_EXEC : S_OPER;
                        remain <= 8'h00;
                    end
                end
                S_OPER: begin
                    // Each byte lands at its own lane; the last one ends
                    // collection and the countdown loads on the next edge
                    if (byte_valid_i) begin
                        // Operands arrive low byte first
                        case (got)
                            3'h0: oper[7:0] <= byte_i;
                            3'h1: oper[15:8] <= byte_i;
                            3'h2: oper[23:16] <= byte_i;
                            default: oper[31:24] <= byte_i;
                        endcase
                        got <= got + 3'h1;
                        if (got + 3'h1 == need)
                            state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    // Load the count, run it down to one, then report; the
                    // transfer therefore occupies clocks plus one cycles
                    if (remain == 8'h00) begin
                        remain <= exec_clk;
                        clocks_o <= exec_clk;
                    end else if (remain == 8'h01) begin
                        // Final edge: publish the result and take bytes again
                        state <= S_OPC;
                        remain <= 8'h00;
                        done_o <= 1'b1;
                        taken_o <= br;
                        kind_o <= kind;
                        operand_lo_o <= oper[15:0];
                        operand_hi_o <= oper[31:16];
                        sp_add_o <= (opcode == `CTD_OP_RET_NEAR_IMM) |
                                    (opcode == `CTD_OP_RET_FAR_IMM);
                        if (kind == K_LOOP) begin
                            count_write_o <= 1'b1;
                            count_next_o <= cnt_dec;
                        end
                    end else begin
                        remain <= remain - 8'h01;
                    end
                end
                // Unused state codes fall back to waiting for an opcode
                default: state <= S_OPC;
            endcase
        end
    end

    // Nothing here drives the stack pointer or count register itself;
    // the core applies operand_lo_o and count_next_o when told to.
endmodule // ctd_decode

// *** core/ctd_defines.vh ***
// Purpose: Constants for the control-transfer decode and timing block
// Assumes: Byte-wide instruction stream, flag inputs from the core
// Notes:   Timings are processor clocks, one clock per ref_clk_i edge
`ifndef CTD_DEFINES_VH
`define CTD_DEFINES_VH
// Opcodes
`define CTD_OP_JMP_NEAR     8'hE9
`define CTD_OP_JMP_SHORT    8'hEB
`define CTD_OP_JMP_FAR      8'hEA
`define CTD_OP_GROUP_FF     8'hFF
`define CTD_OP_RET_NEAR     8'hC3
`define CTD_OP_RET_NEAR_IMM 8'hC2
`define CTD_OP_RET_FAR      8'hCB
`define CTD_OP_RET_FAR_IMM  8'hCA
`define CTD_OP_JCC_HI       4'h7
`define CTD_OP_LOOP_NZ      8'hE0
`define CTD_OP_LOOP_Z       8'hE1
`define CTD_OP_LOOP         8'hE2
`define CTD_OP_JUMP_IF_COUNT_ZERO_OP      8'hE3
// Mode byte middle field values
`define CTD_MID_JMP_IND_NEAR 3'h4
`define CTD_MID_JMP_IND_FAR  3'h5
// Condition codes (low nibble of 0x7x)
`define CTD_CC_O   4'h0
`define CTD_CC_NO  4'h1
`define CTD_CC_B   4'h2
`define CTD_CC_AE  4'h3
`define CTD_CC_Z   4'h4
`define CTD_CC_NZ  4'h5
`define CTD_CC_BE  4'h6
`define CTD_CC_A   4'h7
`define CTD_CC_S   4'h8
`define CTD_CC_NS  4'h9
`define CTD_CC_PE  4'hA
`define CTD_CC_PO  4'hB
`define CTD_CC_L   4'hC
`define CTD_CC_GE  4'hD
`define CTD_CC_LE  4'hE
`define CTD_CC_G   4'hF
// Execution clocks
`define CTD_T_JMP_DIRECT   8'h07
`define CTD_T_JMP_IND_NEAR 8'h07
`define CTD_T_JMP_IND_FAR  8'h10
`define CTD_T_RET_NEAR     8'h08
`define CTD_T_RET_NEAR_IMM 8'h0C
`define CTD_T_RET_FAR      8'h12
`define CTD_T_RET_FAR_IMM  8'h11
`define CTD_T_JCC_TAKEN    8'h08
`define CTD_T_JCC_NOT      8'h04
`define CTD_T_LOOP_TAKEN   8'h0B
`define CTD_T_LOOP_NOT     8'h05
`define CTD_T_LOOPB_TAKEN  8'h11
`define CTD_T_LOOPB_NOT    8'h05
`define CTD_T_JUMP_IF_COUNT_ZERO_TAKEN   8'h09
`define CTD_T_JUMP_IF_COUNT_ZERO_NOT     8'h05
`define CTD_T_QUEUE_REFILL 8'h08
`endif

// *** sim/ctd_decode_chk.sv ***
// Purpose: Port assertions for the control-transfer decoder
// Assumes: Flags and count stay steady while an instruction runs
// Notes:   Helper logic tracks the running opcode and the refusal span
`timescale 1ns/100ps
module ctd_decode_chk (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire        byte_valid_i,
    input wire [7:0]  byte_i,
    input wire        zero_flag_i,
    input wire        carry_flag_i,
    input wire        sign_flag_i,
    input wire        overflow_flag_i,
    input wire        parity_flag_i,
    input wire [15:0] count_register_i,
    input wire        byte_ready_o,
    input wire        done_o,
    input wire        taken_o,
    input wire [3:0]  kind_o,
    input wire [7:0]  clocks_o
);
    logic [7:0] op;
    logic       want;
    logic [8:0] busy;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Opcode capture and count of cycles spent refusing bytes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            want <= 1'b1;
            busy <= 9'h000;
        end else begin
            busy <= byte_ready_o ? 9'h000 : busy + 9'h001;
            if (byte_valid_i && byte_ready_o && (want || done_o))
                op <= byte_i;
            if (byte_valid_i && byte_ready_o)
                want <= 1'b0;
            else if (done_o)
                want <= 1'b1;
        end
    end
    // Flag test picked by the low opcode nibble; odd codes negate it
    function automatic logic cc_true(input logic [3:0] cc, input logic z, c, s, o, p);
        logic [7:0] t;
        t = {(s ^ o) | z, s ^ o, p, s, c | z, z, c, o};
        return t[cc[3:1]] ^ cc[0];
    endfunction
    sequence s_end; !byte_ready_o ##1 byte_ready_o; endsequence
    property p_end; s_end |-> done_o; endproperty
    a_end: assert property (p_end) else $error("ready back without done");
    property p_span; done_o |-> busy == {1'b0, clocks_o} + 9'h001; endproperty
    a_span: assert property (p_span) else $error("busy span differs from clocks");
    property p_cc; done_o && kind_o == 4'h8 |-> taken_o == cc_true(op[3:0], zero_flag_i,
        carry_flag_i, sign_flag_i, overflow_flag_i, parity_flag_i); endproperty
    a_cc: assert property (p_cc) else $error("branch condition wrong");
    property p_jcc; done_o && kind_o == 4'h8 |-> clocks_o == (taken_o ? 8'h10 : 8'h04); endproperty
    a_jcc: assert property (p_jcc) else $error("conditional clocks wrong");
    property p_ret; done_o && (op == 8'hC2 || op == 8'hCA) |->
        clocks_o == (op[3] ? 8'h19 : 8'h14) && kind_o == (op[3] ? 4'h7 : 4'h6); endproperty
    a_ret: assert property (p_ret) else $error("return with immediate wrong");
    property p_dir; done_o && (op == 8'hE9 || op == 8'hEA || op == 8'hEB) |->
        taken_o && clocks_o == 8'h0F; endproperty
    a_dir: assert property (p_dir) else $error("direct jump wrong");
    property p_loop; done_o && (op == 8'hE0 || op == 8'hE1) |-> clocks_o == (taken_o ? 8'h13 : 8'h05)
        && taken_o == (count_register_i != 16'h0001 && zero_flag_i == op[0]); endproperty
    a_loop: assert property (p_loop) else $error("loop outcome wrong");
    property p_cxz; done_o && op == 8'hE3 |-> taken_o == (count_register_i == 16'h0000)
        && clocks_o == (taken_o ? 8'h11 : 8'h05); endproperty
    a_cxz: assert property (p_cxz) else $error("count-zero jump wrong");
endmodule // ctd_decode_chk
bind ctd_decode ctd_decode_chk u_chk (.*);

// *** sim/ctd_decode_tb_top.sv ***
// Purpose: Self-checking bench for the control-transfer decoder
// Assumes: Flags and count change only between instructions
// Notes:   Table rows, a full condition sweep, then hand tests
`timescale 1ns/100ps
module ctd_decode_tb_top;
    typedef struct {
        logic [39:0] code;
        int          nb;
        logic [4:0]  fl;
        logic [15:0] cx;
        logic [3:0]  kind;
        logic        tk;
        logic [7:0]  clks;
    } ctd_row_t;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        slow = 1'b0;
    logic        byte_valid_i, byte_ready_o, done_o, taken_o, sp_add_o, count_write_o;
    logic        zero_flag_i, carry_flag_i, sign_flag_i, overflow_flag_i, parity_flag_i;
    logic [7:0]  byte_i, ea_clocks_i, clocks_o;
    logic [3:0]  kind_o;
    logic [15:0] count_register_i, operand_lo_o, operand_hi_o, count_next_o;
    int          mismatches = 0, total_checks = 0, cyc = 0, last = 0;
    ctd_row_t    r;
    // Flags packed as overflow, sign, zero, parity, carry
    ctd_row_t rows [0:15] = '{
        '{40'h00001234E9, 3, 5'h00, 16'h0, 4'h1, 1'b1, 8'h0F},
        '{40'h44332211EA, 5, 5'h00, 16'h0, 4'h3, 1'b1, 8'h0F},
        '{40'h00000026FF, 2, 5'h00, 16'h0, 4'h4, 1'b1, 8'h15},
        '{40'h0000002EFF, 2, 5'h00, 16'h0, 4'h5, 1'b1, 8'h1E},
        '{40'h00000010C2, 3, 5'h00, 16'h0, 4'h6, 1'b1, 8'h14},
        '{40'h00008004CA, 3, 5'h00, 16'h0, 4'h7, 1'b1, 8'h19},
        '{40'h000000F074, 2, 5'h04, 16'h0, 4'h8, 1'b1, 8'h10},
        '{40'h000000F074, 2, 5'h00, 16'h0, 4'h8, 1'b0, 8'h04},
        '{40'h0000000277, 2, 5'h04, 16'h0, 4'h8, 1'b0, 8'h04},
        '{40'h000000027F, 2, 5'h18, 16'h0, 4'h8, 1'b1, 8'h10},
        '{40'h000000FEE1, 2, 5'h04, 16'h2, 4'h9, 1'b1, 8'h13},
        '{40'h000000FEE1, 2, 5'h04, 16'h1, 4'h9, 1'b0, 8'h05},
        '{40'h000000FEE0, 2, 5'h00, 16'h5, 4'h9, 1'b1, 8'h13},
        '{40'h00000010E3, 2, 5'h00, 16'h0, 4'hA, 1'b1, 8'h11},
        '{40'h00000010E3, 2, 5'h00, 16'h1, 4'hA, 1'b0, 8'h05},
        '{40'h0000000090, 1, 5'h00, 16'h0, 4'hF, 1'b0, 8'h01}};
    ctd_decode dut (.*);
    ctd_fetch_model fetch (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .slow_i      (slow),
        .byte_ready_i(byte_ready_o),
        .byte_valid_o(byte_valid_i),
        .byte_o      (byte_i)
    );
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    // Edge count and the edge of the latest byte taken
    always @(posedge ref_clk_i) begin
        cyc++;
        if (byte_valid_i && byte_ready_o)
            last = cyc;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic push(input ctd_row_t x);
        @(posedge ref_clk_i);
        {overflow_flag_i, sign_flag_i, zero_flag_i, parity_flag_i, carry_flag_i} <= x.fl;
        count_register_i <= x.cx;
        #1;
        for (int i = 0; i < x.nb; i++)
            fetch.fifo.push_back(x.code[8*i+:8]);
    endtask
    task automatic await(input ctd_row_t x, input bit full);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        #1;
        while (done_o !== 1'b1 && n < 300) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check("done", 16'h1, {15'h0, done_o});
        check("kind", {12'h0, x.kind}, {12'h0, kind_o});
        if (full) begin
            check("taken", {15'h0, x.tk}, {15'h0, taken_o});
            check("clocks", {8'h0, x.clks}, {8'h0, clocks_o});
            check("span", 16'(x.clks + 1), 16'(cyc - last));
            check("sp_add", {15'h0, x.kind inside {4'h6, 4'h7}}, {15'h0, sp_add_o});
            check("count_write", {15'h0, x.kind == 4'h9}, {15'h0, count_write_o});
            if (x.kind == 4'h9)
                check("count_next", x.cx - 16'h1, count_next_o);
            if (x.nb > 1)
                check("operand_lo", x.code[23:8], operand_lo_o);
            if (x.nb > 3)
                check("operand_hi", x.code[39:24], operand_hi_o);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {overflow_flag_i, sign_flag_i, zero_flag_i, parity_flag_i, carry_flag_i} = 5'h00;
        count_register_i = 16'h0000;
        ea_clocks_i = 8'h06;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            push(rows[i]);
            await(rows[i], 1'b1);
        end
        // Every condition code against every flag pattern
        for (int k = 0; k < 512; k++) begin
            r = '{{24'h0, 8'h02, 4'h7, k[8:5]}, 2, k[4:0], 16'h0, 4'h8, 1'b0, 8'h00};
            push(r);
            await(r, 1'b0);
        end
        // Back to back with a slow queue
        slow <= 1'b1;
        r = '{40'h00000005EB, 2, 5'h04, 16'h0, 4'h2, 1'b1, 8'h0F};
        push(r);
        push(rows[6]);
        await(r, 1'b1);
        await(rows[6], 1'b1);
        slow <= 1'b0;
        // Zero address time on the indirect near form
        ea_clocks_i <= 8'h00;
        r = rows[2];
        r.clks = 8'h0F;
        push(r);
        await(r, 1'b1);
        // Reset in mid-instruction clears the outputs
        push(rows[6]);
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        check("reset kind", 16'h0, {12'h0, kind_o});
        check("reset clocks", 16'h0, {8'h0, clocks_o});
        check("reset ready", 16'h1, {15'h0, byte_ready_o});
        push(rows[0]);
        await(rows[0], 1'b1);
        give_verdict();
    end
    initial begin
        #2_000_000;
        mismatches++;
        give_verdict();
    end
endmodule // ctd_decode_tb_top

// *** sim/ctd_fetch_model.sv ***
// Purpose: Instruction fetch queue feeding the decoder
// Assumes: Bench pushes whole instructions into the queue
// Notes:   Slow mode idles a cycle after each byte taken
`timescale 1ns/100ps
module ctd_fetch_model (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        slow_i,
    input  wire        byte_ready_i,
    output logic       byte_valid_o,
    output logic [7:0] byte_o
);
    logic [7:0] fifo [$];
    logic       took;
    initial byte_valid_o = 1'b0;
    initial byte_o = 8'hA5;
    // Head byte held until taken; idle line flips so stale bytes never match
    always @(posedge ref_clk_i) begin
        took = byte_valid_o && byte_ready_i && !rst_i;
        if (took)
            void'(fifo.pop_front());
        if (rst_i || fifo.size() == 0 || (took && slow_i)) begin
            byte_valid_o <= 1'b0;
            byte_o       <= ~byte_o;
        end else begin
            byte_valid_o <= 1'b1;
            byte_o       <= fifo[0];
        end
    end
endmodule // ctd_fetch_model
